// File: sir_card_model.sv
`default_nettype none
module sir_card_model (
  input  wire logic        hclk,
  input  wire logic        inserted,
  input  wire logic [15:0] io_addr,
  input  wire logic [1:0]  card_enable_n,
  output logic             card_detect_one,
  output logic             card_detect_two,
  output logic             io_is_16_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  // detect pins are pulled up while the socket is empty
  assign card_detect_one = !inserted;
  assign card_detect_two = !inserted;
  // released line toggles so a stale level is never mistaken for an answer
  always_ff @(posedge hclk)
    flip <= !flip;
  // port width decoded from address bit 3 only: bit 3 low means 16-bit
  assign io_is_16_n = (card_enable_n != 2'b11) ? io_addr[3] : flip;
endmodule
`default_nettype wire

// File: sir_pkg.sv
`default_nettype none
package sir_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_IF_STATUS        = 6'h01;
  localparam logic [5:0] IDX_IRQ_GEN_CTRL     = 6'h03;
  localparam logic [5:0] IDX_CSC_FLAGS        = 6'h04;
  localparam logic [5:0] IDX_CSC_CFG          = 6'h05;
  localparam logic [5:0] IDX_IO_WIN_CTRL      = 6'h07;
  localparam logic [5:0] IDX_W0_START_LO      = 6'h08;
  localparam logic [5:0] IDX_W0_START_HI      = 6'h09;
  localparam logic [5:0] IDX_W0_STOP_LO       = 6'h0A;
  localparam logic [5:0] IDX_W0_STOP_HI       = 6'h0B;
  localparam logic [5:0] IDX_W1_START_LO      = 6'h0C;
  localparam logic [5:0] IDX_W1_START_HI      = 6'h0D;
  localparam logic [5:0] IDX_W1_STOP_LO       = 6'h0E;
  localparam logic [5:0] IDX_W1_STOP_HI       = 6'h0F;
  localparam logic [5:0] IDX_CARD_DETECT_CTRL = 6'h16;
  localparam int unsigned IDX_LSB             = 2;
  localparam int unsigned DECODE_MSB          = 7;
  // card_irq_general_control fields
  localparam int unsigned BIT_CARD_RESET_N    = 6;
  localparam int unsigned BIT_CARD_TYPE_IO    = 5;
  localparam int unsigned IO_IRQ_SEL_LSB      = 0;
  localparam logic [7:0]  IRQ_GEN_MASK        = 8'h6F;
  // status_change_irq_config fields
  localparam int unsigned CSC_IRQ_SEL_LSB     = 4;
  localparam int unsigned BIT_DETECT_EN       = 3;
  localparam int unsigned BIT_READY_EN        = 2;
  localparam int unsigned BIT_BWARN_EN        = 1;
  localparam int unsigned BIT_BDEAD_EN        = 0;
  localparam int unsigned IRQ_SEL_W           = 4;
  // io_window_control fields
  localparam int unsigned BIT_W1_SIZE         = 4;
  localparam int unsigned BIT_W0_SIZE         = 0;
  localparam logic [7:0]  IO_CTRL_MASK        = 8'h11;
  // card_detect_control fields
  localparam int unsigned BIT_SW_DETECT       = 5;
  localparam int unsigned BIT_CFG_RESET_EN    = 1;
  // card_status_change flag bits, write one to clear
  localparam int unsigned FLAG_BDEAD          = 0;
  localparam int unsigned FLAG_BWARN          = 1;
  localparam int unsigned FLAG_READY          = 2;
  localparam int unsigned FLAG_DETECT         = 3;
  localparam int unsigned FLAG_W              = 4;
  // synchronised pin vector positions
  localparam int unsigned PIN_CD1             = 0;
  localparam int unsigned PIN_CD2             = 1;
  localparam int unsigned PIN_READY           = 2;
  localparam int unsigned PIN_STATUS_CHANGE_N          = 3;
  localparam int unsigned PIN_BWARN           = 4;
  localparam int unsigned PIN_IO16            = 5;
  localparam int unsigned PIN_W               = 6;
  localparam int unsigned IRQ_LINES           = 16;
  localparam logic [7:0]  REG_RESET           = 8'h00;
  localparam logic [15:0] ADDR_RESET          = 16'h0000;
endpackage
`default_nettype wire

// File: sir_socket_regs.sv
`default_nettype none
module sir_socket_regs (
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic                                   hreadyout,
  output logic                                   hresp,
  output logic      [31:0]                       hrdata,
  input  wire logic                              card_detect_one,
  input  wire logic                              card_detect_two,
  input  wire logic                              ready_busy_n,
  input  wire logic                              status_change_n,
  input  wire logic                              batt_warn_n,
  input  wire logic                              io_is_16_n,
  input  wire logic [1:0]                        card_enable_n,
  input  wire logic [15:0]                       io_addr,
  input  wire logic                              io_req,
  output logic                                   card_reset,
  output logic                                   card_is_io,
  output logic      [1:0]                        win_hit,
  output logic                                   io_word_path,
  output logic                                   io_word_cycle,
  output logic      [sir_pkg::IRQ_LINES-1:0]     io_irq_line,
  output logic      [sir_pkg::IRQ_LINES-1:0]     csc_irq_line,
  output logic                                   cfg_reset_pulse
);
  import sir_pkg::*;

  typedef struct packed {
    logic              ph_valid;
    logic              ph_write;
    logic              ph_mapped;
    logic [5:0]        ph_index;
    logic [31:0]       rdata;
    logic [7:0]        irq_gen;
    logic [7:0]        csc_cfg;
    logic [7:0]        io_ctrl;
    logic [15:0]       w0_start;
    logic [15:0]       w0_stop;
    logic [15:0]       w1_start;
    logic [15:0]       w1_stop;
    logic              cfg_reset_en;
    logic [FLAG_W-1:0] csc_flags;
    logic [1:0]        warm;
    logic              primed;
    logic              cd1_prev;
    logic              cd2_prev;
    logic              rdy_prev;
    logic              status_change_n_prev;
    logic              bwarn_prev;
    logic              cfg_rst;
  } sir_state_type;

  sir_state_type st;
  sir_state_type next_st;

  logic [PIN_W-1:0] pins;
  logic             take;
  logic             wr;
  logic [7:0]       wdat;
  logic             sw_detect;
  logic [FLAG_W-1:0] flag_clear;
  logic [FLAG_W-1:0] events;
  logic             cd_change;
  logic             is_io;
  logic [1:0]       win_word;
  logic             io16_qualified;

  // one-hot system line; select value zero routes nowhere
  function automatic logic [IRQ_LINES-1:0] line_decode(input logic [IRQ_SEL_W-1:0] sel);
    logic [IRQ_LINES-1:0] line;
    line = '0;
    if (sel != '0)
      line[sel] = 1'b1;
    return line;
  endfunction

  function automatic logic index_mapped(input logic [5:0] idx);
    logic ok;
    ok = 1'b0;
    if ((idx == IDX_IF_STATUS) || (idx == IDX_IRQ_GEN_CTRL) || (idx == IDX_CSC_FLAGS) ||
        (idx == IDX_CSC_CFG) || (idx == IDX_CARD_DETECT_CTRL) ||
        ((idx >= IDX_IO_WIN_CTRL) && (idx <= IDX_W1_STOP_HI)))
      ok = 1'b1;
    return ok;
  endfunction

  function automatic logic [7:0] read_value(input logic [5:0] idx, input sir_state_type s,
                                            input logic [PIN_W-1:0] p);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_IF_STATUS:
      begin
        v[0] = p[PIN_STATUS_CHANGE_N];
        v[1] = p[PIN_BWARN];
        v[2] = p[PIN_CD1];
        v[3] = p[PIN_CD2];
        v[5] = p[PIN_READY];
      end
      IDX_IRQ_GEN_CTRL:     v = s.irq_gen;
      IDX_CSC_FLAGS:        v = {4'h0, s.csc_flags};
      IDX_CSC_CFG:          v = s.csc_cfg;
      IDX_IO_WIN_CTRL:      v = s.io_ctrl;
      IDX_W0_START_LO:      v = s.w0_start[7:0];
      IDX_W0_START_HI:      v = s.w0_start[15:8];
      IDX_W0_STOP_LO:       v = s.w0_stop[7:0];
      IDX_W0_STOP_HI:       v = s.w0_stop[15:8];
      IDX_W1_START_LO:      v = s.w1_start[7:0];
      IDX_W1_START_HI:      v = s.w1_start[15:8];
      IDX_W1_STOP_LO:       v = s.w1_stop[7:0];
      IDX_W1_STOP_HI:       v = s.w1_stop[15:8];
      // software detect bit is never stored, so it reads zero
      IDX_CARD_DETECT_CTRL: v[BIT_CFG_RESET_EN] = s.cfg_reset_en;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  sir_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({io_is_16_n, batt_warn_n, status_change_n, ready_busy_n, card_detect_two, card_detect_one}),
    .sync_out (pins)
  );

  sir_win_decode #(
    .ADDR_W (16)
  ) u_win0 (
    .io_addr    (io_addr),
    .io_req     (io_req),
    .start_addr (st.w0_start),
    .stop_addr  (st.w0_stop),
    .size_16    (st.io_ctrl[BIT_W0_SIZE]),
    .hit        (win_hit[0]),
    .word_path  (win_word[0])
  );

  sir_win_decode #(
    .ADDR_W (16)
  ) u_win1 (
    .io_addr    (io_addr),
    .io_req     (io_req),
    .start_addr (st.w1_start),
    .stop_addr  (st.w1_stop),
    .size_16    (st.io_ctrl[BIT_W1_SIZE]),
    .hit        (win_hit[1]),
    .word_path  (win_word[1])
  );

  assign is_io = st.irq_gen[BIT_CARD_TYPE_IO];

  always_comb
  begin
    next_st    = st;
    sw_detect  = 1'b0;
    flag_clear = '0;
    wdat       = hwdata[7:0];
    take       = hsel && htrans[1] && hready;
    wr         = st.ph_valid && st.ph_write && st.ph_mapped;

    // data phase write; narrow registers sit in the low byte
    if (wr)
    begin
      unique case (st.ph_index)
        IDX_IRQ_GEN_CTRL:     next_st.irq_gen = wdat & IRQ_GEN_MASK;
        IDX_CSC_FLAGS:        flag_clear = wdat[FLAG_W-1:0];
        IDX_CSC_CFG:          next_st.csc_cfg = wdat;
        IDX_IO_WIN_CTRL:      next_st.io_ctrl = wdat & IO_CTRL_MASK;
        IDX_W0_START_LO:      next_st.w0_start[7:0] = wdat;
        IDX_W0_START_HI:      next_st.w0_start[15:8] = wdat;
        IDX_W0_STOP_LO:       next_st.w0_stop[7:0] = wdat;
        IDX_W0_STOP_HI:       next_st.w0_stop[15:8] = wdat;
        IDX_W1_START_LO:      next_st.w1_start[7:0] = wdat;
        IDX_W1_START_HI:      next_st.w1_start[15:8] = wdat;
        IDX_W1_STOP_LO:       next_st.w1_stop[7:0] = wdat;
        IDX_W1_STOP_HI:       next_st.w1_stop[15:8] = wdat;
        IDX_CARD_DETECT_CTRL:
        begin
          sw_detect            = wdat[BIT_SW_DETECT];
          next_st.cfg_reset_en = wdat[BIT_CFG_RESET_EN];
        end
        default:              sw_detect = 1'b0;
      endcase
    end

    // pin history; the synchroniser shows zeros for two edges after reset,
    // so edges count only once its output and the history are both real
    next_st.warm        = {st.warm[0], 1'b1};
    next_st.primed      = st.warm[1];
    next_st.cd1_prev    = pins[PIN_CD1];
    next_st.cd2_prev    = pins[PIN_CD2];
    next_st.rdy_prev    = pins[PIN_READY];
    next_st.status_change_n_prev = pins[PIN_STATUS_CHANGE_N];
    next_st.bwarn_prev  = pins[PIN_BWARN];

    cd_change = st.primed && ((pins[PIN_CD1] != st.cd1_prev) || (pins[PIN_CD2] != st.cd2_prev));

    events = '0;
    events[FLAG_DETECT] = st.csc_cfg[BIT_DETECT_EN] && (cd_change || sw_detect);
    events[FLAG_READY]  = st.csc_cfg[BIT_READY_EN] && !is_io && st.primed &&
                          pins[PIN_READY] && !st.rdy_prev;
    events[FLAG_BWARN]  = st.csc_cfg[BIT_BWARN_EN] && st.primed &&
                          !pins[PIN_BWARN] && st.bwarn_prev;
    // memory card: battery dead; I/O card: status change pulled low
    events[FLAG_BDEAD]  = st.csc_cfg[BIT_BDEAD_EN] && st.primed &&
                          !pins[PIN_STATUS_CHANGE_N] && st.status_change_n_prev;

    // a new event beats a clear in the same cycle
    next_st.csc_flags = (st.csc_flags & ~flag_clear) | events;

    // both detect inputs going high requests a configuration reset
    next_st.cfg_rst = st.cfg_reset_en && st.primed && pins[PIN_CD1] && pins[PIN_CD2] &&
                      !(st.cd1_prev && st.cd2_prev);

    // address phase; read data comes from next state so a write just ahead is seen
    if (take)
    begin
      next_st.ph_valid  = 1'b1;
      next_st.ph_write  = hwrite;
      next_st.ph_index  = haddr[DECODE_MSB:IDX_LSB];
      next_st.ph_mapped = (haddr[31:DECODE_MSB+1] == '0) && index_mapped(haddr[DECODE_MSB:IDX_LSB]);
      if (!hwrite && next_st.ph_mapped)
        next_st.rdata = {24'h000000, read_value(haddr[DECODE_MSB:IDX_LSB], next_st, pins)};
      else
        next_st.rdata = 32'h00000000;
    end
    else
    begin
      next_st.ph_valid = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st           <= '0;
      st.irq_gen   <= REG_RESET;
      st.csc_cfg   <= REG_RESET;
      st.io_ctrl   <= REG_RESET;
      st.w0_start  <= ADDR_RESET;
      st.w0_stop   <= ADDR_RESET;
      st.w1_start  <= ADDR_RESET;
      st.w1_stop   <= ADDR_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdata;

  assign card_reset = !st.irq_gen[BIT_CARD_RESET_N];
  assign card_is_io = is_io;

  // in I/O mode the ready pin carries the card interrupt, active low
  assign io_irq_line = (is_io && !pins[PIN_READY]) ?
                       line_decode(st.irq_gen[IO_IRQ_SEL_LSB +: IRQ_SEL_W]) : '0;
  assign csc_irq_line = (st.csc_flags != '0) ?
                        line_decode(st.csc_cfg[CSC_IRQ_SEL_LSB +: IRQ_SEL_W]) : '0;

  // window 0 wins when windows overlap
  assign io_word_path = win_hit[0] ? win_word[0] : win_word[1];
  // io_is_16_n passes the pin synchroniser, so it is valid two edges after enable; the card decodes only while enabled
  assign io16_qualified = (card_enable_n != 2'b11) && !pins[PIN_IO16];
  assign io_word_cycle  = io_word_path && io16_qualified;

  assign cfg_reset_pulse = st.cfg_rst;
endmodule
`default_nettype wire

// File: sir_socket_regs_chk.sv
`default_nettype none
module sir_socket_regs_chk (
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire logic                    ready_busy_n,
  input wire logic                    io_is_16_n,
  input wire logic [1:0]              card_enable_n,
  input wire logic                    io_req,
  input wire logic                    card_reset,
  input wire logic                    card_is_io,
  input wire logic [1:0]              win_hit,
  input wire logic                    io_word_path,
  input wire logic                    io_word_cycle,
  input wire logic [sir_pkg::IRQ_LINES-1:0] io_irq_line,
  input wire logic [sir_pkg::IRQ_LINES-1:0] csc_irq_line,
  input wire logic                    cfg_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // the pin synchronisers hold stale values for a few edges after reset
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  rdata_byte_a: assert property (hrdata[31:8] == 24'h0) else $error("read data above byte set");
  irq_onehot_a: assert property ($onehot0(io_irq_line) && $onehot0(csc_irq_line))
    else $error("irq lines not one-hot");
  io_mode_irq_a: assert property (!card_is_io |-> io_irq_line == '0)
    else $error("card irq in memory mode");
  io_irq_src_a: assert property (io_irq_line != '0 |-> !$past(ready_busy_n, 2))
    else $error("card irq without card request");
  hit_idle_a: assert property (!io_req |-> win_hit == 2'b00 && !io_word_cycle)
    else $error("window hit without access");
  path_hit_a: assert property (io_word_path |-> win_hit != 2'b00) else $error("word path without hit");
  word_cycle_a: assert property (up == 2'h3 |->
    io_word_cycle == (io_word_path && card_enable_n != 2'b11 && !$past(io_is_16_n, 2)))
    else $error("word cycle qualification wrong");
  ctrl_write_a: assert property ($changed({card_reset, card_is_io}) |->
    $past(hsel && htrans[1] && hwrite && hready, 2) || $past(cfg_reset_pulse) || $past(cfg_reset_pulse, 2))
    else $error("card control changed without write");
  cover property (io_word_cycle);
  cover property (csc_irq_line != '0);
  cover property (io_irq_line != '0);
  cover property (win_hit == 2'b11);
endmodule
bind sir_socket_regs sir_socket_regs_chk sir_socket_regs_chk_inst (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .ready_busy_n, .io_is_16_n, .card_enable_n, .io_req, .card_reset, .card_is_io, .win_hit,
  .io_word_path, .io_word_cycle, .io_irq_line, .csc_irq_line, .cfg_reset_pulse);
`default_nettype wire

// File: sir_sync.sv
`default_nettype none
module sir_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import sir_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sir_sync_state_type;

  sir_sync_state_type st;
  sir_sync_state_type next_st;

  // stage1 feeds stage2 only
  always_comb
  begin
    next_st        = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_out = st.stage2;
endmodule
`default_nettype wire

// File: sir_win_decode.sv
`default_nettype none
module sir_win_decode #(
  parameter int ADDR_W = 16
) (
  input  wire logic [ADDR_W-1:0] io_addr,
  input  wire logic              io_req,
  input  wire logic [ADDR_W-1:0] start_addr,
  input  wire logic [ADDR_W-1:0] stop_addr,
  input  wire logic              size_16,
  output logic                   hit,
  output logic                   word_path
);
  import sir_pkg::*;

  // both bounds inclusive: start equal to stop is a one byte window
  always_comb
  begin
    hit       = io_req && (io_addr >= start_addr) && (io_addr <= stop_addr);
    word_path = hit && size_16;
  end
endmodule
`default_nettype wire

// File: tb_sir_socket_regs.sv
`default_nettype none
module tb_sir_socket_regs;
  import sir_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        card_detect_one;
  logic        card_detect_two;
  logic        ready_busy_n = 1'b1;
  logic        status_change_n = 1'b1;
  logic        batt_warn_n = 1'b1;
  logic        io_is_16_n;
  logic [1:0]  card_enable_n = 2'b11;
  logic [15:0] io_addr = 16'h0;
  logic        io_req = 1'b0;
  logic        inserted = 1'b0;
  logic        card_reset;
  logic        card_is_io;
  logic [1:0]  win_hit;
  logic        io_word_path;
  logic        io_word_cycle;
  logic        cfg_reset_pulse;
  logic [IRQ_LINES-1:0] io_irq_line;
  logic [IRQ_LINES-1:0] csc_irq_line;
  logic [31:0] rnd = 32'hB83D;
  logic [31:0] rd;
  logic [31:0] ex;
  logic [15:0] st [2] = '{16'h0, 16'h0};
  logic [15:0] sp [2] = '{16'h0, 16'h0};
  logic [7:0]  sz = 8'h00;
  logic [3:0]  sel;
  int          b;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          pulses = 0;
  logic [5:0]  wi [11] = '{6'h03, 6'h05, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F};

  always #5 hclk = ~hclk;

  // the configuration reset strobe stands for one cycle only
  always @(posedge hclk)
    if (cfg_reset_pulse === 1'b1)
      pulses <= pulses + 1;

  sir_socket_regs sir_socket_regs_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .card_detect_one, .card_detect_two, .ready_busy_n,
    .status_change_n, .batt_warn_n, .io_is_16_n, .card_enable_n, .io_addr, .io_req, .card_reset, .card_is_io,
    .win_hit, .io_word_path, .io_word_cycle, .io_irq_line, .csc_irq_line, .cfg_reset_pulse);
  sir_card_model sir_card_model_inst (.hclk, .inserted, .io_addr, .card_enable_n, .card_detect_one,
    .card_detect_two, .io_is_16_n);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  function automatic logic [1:0] hits(input logic [15:0] a);
    hits = 2'b00;
    for (int w = 0; w < 2; w++)
      hits[w] = (a >= st[w]) && (a <= sp[w]);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after an edge; each call is an address phase then an idle data phase, so back-to-back calls never overlap
  task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
  endtask

  task automatic probe(input logic [15:0] a);
    logic [1:0] h;
    logic       p;
    h = hits(a);
    p = h[0] ? sz[0] : (h[1] ? sz[4] : 1'b0);
    io_addr <= a;
    io_req <= 1'b1;
    card_enable_n <= 2'b10;
    repeat (4) @(posedge hclk);
    chk(32'(win_hit), 32'(h));
    chk(32'(io_word_path), 32'(p));
    chk(32'(io_word_cycle), 32'(p && !a[3]));
    io_req <= 1'b0;
    card_enable_n <= 2'b11;
    @(posedge hclk);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    final_report;
  end

  initial
  begin
    // second pass resets mid-run, after random writes
    for (int r = 0; r < 2; r++)
    begin
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(32'(card_reset), 32'h1);
      probe(16'h0000);
      foreach (wi[i])
      begin
        bus(wi[i], 1'b0, 8'h00);
        chk(rd, 32'h0);
      end
      for (int n = 0; n < 22; n++)
      begin
        rnd = lfsr(rnd);
        bus(wi[n % 11], 1'b1, rnd[7:0]);
        bus(wi[n % 11], 1'b0, 8'h00);
        ex = {24'h0, rnd[7:0] & (n % 11 == 0 ? IRQ_GEN_MASK : (n % 11 == 2 ? IO_CTRL_MASK : 8'hFF))};
        chk(rd, ex);
      end
    end
    bus(6'h3F, 1'b1, 8'hFF);
    bus(6'h3F, 1'b0, 8'h00);
    chk(rd, 32'h0);
    bus(IDX_CARD_DETECT_CTRL, 1'b1, 8'h20);
    bus(IDX_CARD_DETECT_CTRL, 1'b0, 8'h00);
    chk(rd, 32'h0);
    for (int i = 0; i < 32; i++)
    begin
      ready_busy_n <= i[1];
      bus(IDX_IRQ_GEN_CTRL, 1'b1, {1'b0, i[0], i[4], 1'b0, i[3:0]});
      repeat (3) @(posedge hclk);
      chk(32'(card_reset), 32'(!i[0]));
      chk(32'(card_is_io), 32'(i[4]));
      chk(32'(io_irq_line), (i[4] && !i[1] && i[3:0] != 0) ? 32'h1 << i[3:0] : 32'h0);
    end
    for (int n = 0; n < 6; n++)
    begin
      rnd = lfsr(rnd);
      sz = rnd[7:0] & IO_CTRL_MASK;
      st[0] = rnd[15:0] & 16'hFFF0;
      st[1] = rnd[31:16] & 16'hFFF0;
      sp[0] = st[0] + (n == 0 ? 16'h0 : {13'h0, rnd[10:8]});
      sp[1] = st[1] + {13'h0, rnd[26:24]};
      bus(IDX_IO_WIN_CTRL, 1'b1, sz);
      for (int w = 0; w < 2; w++)
      begin
        bus(6'(8 + 4 * w), 1'b1, st[w][7:0]);
        bus(6'(9 + 4 * w), 1'b1, st[w][15:8]);
        bus(6'(10 + 4 * w), 1'b1, sp[w][7:0]);
        bus(6'(11 + 4 * w), 1'b1, sp[w][15:8]);
      end
      for (int w = 0; w < 2; w++)
      begin
        probe(st[w] - 16'h1);
        probe(st[w]);
        probe(sp[w]);
        probe(sp[w] + 16'h1);
      end
    end
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 5; k++)
        for (int e = 0; e < 2; e++)
        begin
          rnd = lfsr(rnd);
          sel = rnd[3:0];
          b = (k < 2) ? 3 : 4 - k;
          ready_busy_n <= (k != 2);
          bus(IDX_IRQ_GEN_CTRL, 1'b1, {2'b01, 1'(m), 5'h00});
          bus(IDX_CSC_CFG, 1'b1, {sel, 4'(e << b)});
          bus(IDX_CSC_FLAGS, 1'b1, 8'h0F);
          case (k)
            0: inserted <= !inserted;
            1: bus(IDX_CARD_DETECT_CTRL, 1'b1, 8'h20);
            2: ready_busy_n <= 1'b1;
            3: batt_warn_n <= 1'b0;
            default: status_change_n <= 1'b0;
          endcase
          repeat (6) @(posedge hclk);
          ex = (e == 1 && !(k == 2 && m == 1)) ? 32'h1 << b : 32'h0;
          chk(32'(csc_irq_line), (ex != 0 && sel != 0) ? 32'h1 << sel : 32'h0);
          bus(IDX_CSC_FLAGS, 1'b0, 8'h00);
          chk(rd, ex);
          bus(IDX_IF_STATUS, 1'b0, 8'h00);
          chk(32'(rd[0]), 32'(k != 4));
          batt_warn_n <= 1'b1;
          status_change_n <= 1'b1;
        end
    // configuration reset enable reads back; insert then remove gives one strobe
    bus(IDX_CARD_DETECT_CTRL, 1'b1, 8'h02);
    bus(IDX_CARD_DETECT_CTRL, 1'b0, 8'h00);
    chk(rd, 32'h1 << BIT_CFG_RESET_EN);
    inserted <= 1'b1;
    repeat (6) @(posedge hclk);
    b = pulses;
    inserted <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(32'(pulses - b), 32'h1);
    final_report;
  end
endmodule
`default_nettype wire
